/* backplane_bus.sv */
/*
  Processor-card end of the card backplane: runs bus cycles requested
  on a simple user port, drives address, strobes and data, hands the
  address bus to an external master, stops on halt, and prioritises
  the interrupt lines.
  Assumes all inputs synchronous to REF_CLK; RST asynchronous, high.
*/
// Notes on behaviour
// [R1] - Cards are chosen only by the address on the bus, never by slot.
// [R2] - The data bus is driven only for writes and floats otherwise.
// [R3] - One 16-line address bus covers memory and I/O alike.
// [R4] - A low reset line restarts the processor and all cards.
// [R5] - The reset line is made here and shared by every card.
// [R6] - All transfers are timed by the one 1 MHz phase clock.
// [R7] - Read/write is high for read, low for write, and high when idle.
// [R8] - The valid-address strobe is high only while the address holds.
// [R9] - Preselect is high for accesses in the I/O region, low elsewhere.
// [R10] - A mains-rate tick is supplied at 50 or 60 Hz.
// [R11] - A low bus-release request makes the address bus float.
// [R12] - Bus-available rests low and rises only when the bus is released.
// [R13] - A low halt finishes the current cycle, then stops with strobe low.
// [R14] - A 19230 Hz square wave is provided for the serial adapters.
// [R15] - Eight low interrupt lines are ranked, line 7 highest.
// [R16] - The unmaskable line is always served after the current cycle.
// [R17] - Cards answer only to a strobed address in their own range.
`timescale 1ns/1ps
`default_nettype none

module backplane_bus
  import backplane_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W,
  parameter int DATA_WIDTH = DATA_W
)(
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  // User side
  input  wire logic                  REQ_VALID,
  output logic                       REQ_READY,
  input  wire logic                  REQ_WRITE,
  input  wire logic [ADDR_WIDTH-1:0] REQ_ADDR,
  input  wire logic [DATA_WIDTH-1:0] REQ_WDATA,
  input  wire logic                  WAIT_REQ,
  input  wire logic                  MAINS_60HZ,
  input  wire logic                  IRQ_MASK,
  output logic                       RSP_VALID,
  output logic [DATA_WIDTH-1:0]      RSP_RDATA,
  output logic                       IRQ_PENDING,
  output logic [2:0]                 IRQ_LEVEL,
  output logic                       NMI_PENDING,
  input  wire logic                  IRQ_ACK,
  input  wire logic                  NMI_ACK,
  // Backplane
  output logic [ADDR_WIDTH-1:0]      ADDR_O,
  output logic                       ADDR_OE_N,
  input  wire logic [DATA_WIDTH-1:0] DATA_I,
  output logic [DATA_WIDTH-1:0]      DATA_O,
  output logic                       DATA_OE_N,
  output logic                       RESET_N,
  output logic                       PHASE_CLK,
  output logic                       RW,
  output logic                       VALID_ADDRESS_STROBE,
  output logic                       IO_PRESELECT,
  output logic                       MAINS_TICK,
  input  wire logic                  BUS_RELEASE_N,
  output logic                       BUS_AVAILABLE,
  input  wire logic                  HALT_N,
  output logic                       BAUD_CLK,
  input  wire logic [IRQ_LINES-1:0]  PRIORITY_IRQ_N,
  input  wire logic                  NMI_N
);

  clock_gen_if cg ();

  clock_gen u_clock_gen (
    .ref_clk (REF_CLK),
    .rst     (RST),
    .cg      (cg.gen)
  );

  assign cg.mains_60hz = MAINS_60HZ;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_io_region(input logic [ADDR_WIDTH-1:0] a);
    return (a >= IO_BASE) && (a <= IO_LIMIT);
  endfunction

  function automatic logic [2:0] top_irq(input logic [IRQ_LINES-1:0] act);
    logic [2:0] lvl;
    lvl = IRQ_NONE;
    for (int i = 0; i < IRQ_LINES; i++) begin
      if (act[i]) begin
        lvl = 3'(i);
      end
    end
    return lvl;
  endfunction

  typedef struct packed {
    bus_state_type               state;
    logic [ADDR_WIDTH-1:0]       addr;
    logic [DATA_WIDTH-1:0]       wdata;
    logic                        write;
    logic                        io;
    logic                        rsp_valid;
    logic [DATA_WIDTH-1:0]       rdata;
    logic                        released;
    logic                        reset_n;
    logic                        irq_pending;
    logic [2:0]                  irq_level;
    logic                        nmi_pending;
    logic                        nmi_seen_n;
  } bus_ctl_type;

  bus_ctl_type s_reg;
  bus_ctl_type s_next;

  logic [IRQ_LINES-1:0] irq_active;
  logic                 stop_req;

  assign irq_active = ~PRIORITY_IRQ_N;
  assign stop_req   = !HALT_N || WAIT_REQ || !BUS_RELEASE_N;

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_next           = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.reset_n   = 1'b1; // [R4] [R5]
    s_next.nmi_seen_n = NMI_N;

    // Edge-triggered unmaskable request; the mask never touches it
    if (s_reg.nmi_seen_n && !NMI_N) begin
      s_next.nmi_pending = 1'b1; // [R16]
    end else if (NMI_ACK) begin
      s_next.nmi_pending = 1'b0;
    end

    // Level interrupts, re-ranked every cycle so a higher line pre-empts
    s_next.irq_pending = (|irq_active) && !IRQ_MASK; // [R15]
    s_next.irq_level   = top_irq(irq_active); // [R15]
    if (IRQ_ACK && !(|irq_active)) begin
      s_next.irq_pending = 1'b0;
    end

    unique case (s_reg.state)
      ST_IDLE: begin
        if (stop_req) begin
          s_next.state    = ST_STOPPED; // [R13]
          s_next.released = 1'b1;
        end else if (REQ_VALID && cg.phase_fall) begin
          s_next.state = ST_ADDR; // [R6]
          s_next.addr  = REQ_ADDR; // [R1] [R3]
          s_next.wdata = REQ_WDATA;
          s_next.write = REQ_WRITE;
          s_next.io    = in_io_region(REQ_ADDR); // [R9]
        end
      end
      ST_ADDR: begin
        if (cg.phase_fall) begin
          s_next.state = ST_DATA;
        end
      end
      ST_DATA: begin
        // Read data taken on the falling phase edge ends the cycle
        if (cg.phase_fall) begin
          s_next.rsp_valid = 1'b1;
          s_next.rdata     = s_reg.write ? DATA_RESET : DATA_I;
          s_next.state     = ST_IDLE; // [R13]
        end
      end
      ST_STOPPED: begin
        if (!stop_req) begin
          s_next.state    = ST_IDLE;
          s_next.released = 1'b0; // [R12]
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s_reg            <= '0;
      s_reg.state      <= ST_IDLE;
      s_reg.addr       <= ADDR_RESET;
      s_reg.wdata      <= DATA_RESET;
      s_reg.rdata      <= DATA_RESET;
      s_reg.irq_level  <= IRQ_NONE;
      s_reg.nmi_seen_n <= 1'b1;
      s_reg.reset_n    <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Backplane drive
  // ----------------------------------------------------------------
  logic in_cycle;

  assign in_cycle = (s_reg.state == ST_ADDR) || (s_reg.state == ST_DATA);

  assign REQ_READY            = (s_reg.state == ST_IDLE) && !stop_req && cg.phase_fall;
  assign RSP_VALID            = s_reg.rsp_valid;
  assign RSP_RDATA            = s_reg.rdata;
  assign IRQ_PENDING          = s_reg.irq_pending;
  assign IRQ_LEVEL            = s_reg.irq_level;
  assign NMI_PENDING          = s_reg.nmi_pending;
  assign ADDR_O               = s_reg.addr;
  assign ADDR_OE_N            = s_reg.released; // [R11]
  assign DATA_O               = s_reg.wdata;
  assign DATA_OE_N            = !(in_cycle && s_reg.write); // [R2]
  assign RESET_N              = s_reg.reset_n; // [R5]
  assign PHASE_CLK            = cg.phase_clk; // [R6]
  assign RW                   = !(in_cycle && s_reg.write); // [R7]
  assign VALID_ADDRESS_STROBE = in_cycle; // [R8] [R13]
  assign IO_PRESELECT         = in_cycle && s_reg.io; // [R9]
  assign MAINS_TICK           = cg.mains_tick; // [R10]
  assign BUS_AVAILABLE        = s_reg.released; // [R12]
  assign BAUD_CLK             = cg.baud_clk; // [R14]

endmodule

`default_nettype wire

/* backplane_bus_tb.sv */
/* Self-checking bench for backplane_bus with an I/O card model.
   Assumes io_card_model and backplane_chk compiled first. */
`timescale 1ns/1ps
`default_nettype none
module backplane_bus_tb;
  import backplane_pkg::*;
  logic REF_CLK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, REQ_WRITE = 1'b0, WAIT_REQ = 1'b0;
  logic MAINS_60HZ = 1'b0, IRQ_MASK = 1'b0, IRQ_ACK = 1'b0, NMI_ACK = 1'b0, NMI_N = 1'b1;
  logic BUS_RELEASE_N = 1'b1, HALT_N = 1'b1;
  logic [15:0] REQ_ADDR = 16'h0000, ADDR_O, a;
  logic [7:0]  REQ_WDATA = 8'h00, PRIORITY_IRQ_N = 8'hFF, DATA_I, DATA_O, RSP_RDATA;
  logic [2:0]  IRQ_LEVEL;
  logic REQ_READY, RSP_VALID, IRQ_PENDING, NMI_PENDING, ADDR_OE_N, DATA_OE_N, RESET_N, RW;
  logic PHASE_CLK, VALID_ADDRESS_STROBE, IO_PRESELECT, MAINS_TICK, BUS_AVAILABLE, BAUD_CLK;
  int num_errors = 0;
  int cmp_count = 0;
  int ticks = 0;
  int n;
  logic [7:0]  exp_q [$];
  logic [31:0] rng = 32'h0001_0CC1;
  backplane_bus i_dut (
    .REF_CLK(REF_CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .WAIT_REQ(WAIT_REQ),
    .MAINS_60HZ(MAINS_60HZ), .IRQ_MASK(IRQ_MASK), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .IRQ_PENDING(IRQ_PENDING), .IRQ_LEVEL(IRQ_LEVEL), .NMI_PENDING(NMI_PENDING),
    .IRQ_ACK(IRQ_ACK), .NMI_ACK(NMI_ACK), .ADDR_O(ADDR_O), .ADDR_OE_N(ADDR_OE_N),
    .DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N), .RESET_N(RESET_N),
    .PHASE_CLK(PHASE_CLK), .RW(RW), .VALID_ADDRESS_STROBE(VALID_ADDRESS_STROBE),
    .IO_PRESELECT(IO_PRESELECT), .MAINS_TICK(MAINS_TICK), .BUS_RELEASE_N(BUS_RELEASE_N),
    .BUS_AVAILABLE(BUS_AVAILABLE), .HALT_N(HALT_N), .BAUD_CLK(BAUD_CLK),
    .PRIORITY_IRQ_N(PRIORITY_IRQ_N), .NMI_N(NMI_N));
  io_card_model i_card (.clk(REF_CLK), .rst_n(RESET_N), .addr(ADDR_O),
    .strobe(VALID_ADDRESS_STROBE), .presel(IO_PRESELECT), .rw(RW), .wdata(DATA_O), .rdata(DATA_I));
  always #25 REF_CLK = ~REF_CLK;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bound(input int k);
    if (k >= 2000) begin
      num_errors++;
      end_of_test();
    end
  endtask
  // Called at a falling edge; leaves the request up for a back-to-back caller
  task automatic xfer(input logic w, input logic [15:0] ad,
                      input logic [7:0] d, input logic [7:0] e);
    REQ_VALID = 1'b1;
    REQ_WRITE = w;
    REQ_ADDR = ad;
    REQ_WDATA = d;
    n = 0;
    #1;
    while (!REQ_READY) begin
      @(negedge REF_CLK);
      n++;
      bound(n);
    end
    exp_q.push_back(e);
    @(negedge REF_CLK);
  endtask
  task automatic drain;
    for (n = 0; exp_q.size() > 0; n++) begin
      @(negedge REF_CLK);
      bound(n);
    end
  endtask
  function automatic logic pick(input bit b);
    return b ? BAUD_CLK : PHASE_CLK;
  endfunction
  task automatic gap(input bit b, input int e);
    logic v;
    v = pick(b);
    for (n = 0; pick(b) === v; n++) begin @(negedge REF_CLK); bound(n); end
    v = pick(b);
    for (n = 0; pick(b) === v; n++) begin @(negedge REF_CLK); bound(n); end
    chk(16'(n), 16'(e));
  endtask
  // Mains tick period is far longer than this run, so none may appear
  always @(negedge REF_CLK) begin
    if (MAINS_TICK === 1'b1) ticks++;
  end
  // Scoreboard: oldest note against each answer
  always @(negedge REF_CLK) begin
    if (RSP_VALID === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h0001, 16'h0000);
      else chk(RSP_RDATA, exp_q.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge REF_CLK);
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (10) @(negedge REF_CLK);
    chk({RESET_N, RW, DATA_OE_N}, 3'b011);
    RST = 1'b0;
    @(negedge REF_CLK);
    chk({RESET_N, BUS_AVAILABLE}, 2'b10);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      a = (i == 0) ? IO_LIMIT : {4'h8, rng[11:0]};
      xfer(1'b1, a, rng[23:16], 8'h00);
      xfer(1'b0, a, 8'h00, rng[23:16]);
    end
    xfer(1'b1, {4'h9, a[11:0]}, ~rng[23:16], 8'h00);
    xfer(1'b1, {4'h1, a[11:0]}, ~rng[23:16], 8'h00);
    xfer(1'b0, a, 8'h00, rng[23:16]);
    REQ_VALID = 1'b0;
    drain();
    $display("traffic test done");
    gap(1'b0, 10);
    gap(1'b1, 520);
    $display("clock test done");
    for (int i = 0; i < 8; i++) begin
      PRIORITY_IRQ_N = ~((8'h01 << i) | 8'h01);
      repeat (2) @(negedge REF_CLK);
      chk({IRQ_PENDING, IRQ_LEVEL}, {1'b1, 3'(i)});
    end
    IRQ_MASK = 1'b1;
    IRQ_ACK = 1'b1;
    NMI_N = 1'b0;
    repeat (2) @(negedge REF_CLK);
    chk({IRQ_PENDING, NMI_PENDING}, 2'b01);
    NMI_N = 1'b1; IRQ_ACK = 1'b0; NMI_ACK = 1'b1;
    @(negedge REF_CLK);
    NMI_ACK = 1'b0;
    @(negedge REF_CLK);
    chk(NMI_PENDING, 1'b0);
    PRIORITY_IRQ_N = 8'hFF; IRQ_MASK = 1'b0; MAINS_60HZ = 1'b1;
    $display("interrupt test done");
    for (int k = 0; k < 3; k++) begin
      @(negedge REF_CLK);
      xfer(1'b1, 16'h8010, 8'h3C, 8'h00);
      REQ_VALID = 1'b0; HALT_N = (k != 0); BUS_RELEASE_N = (k != 1); WAIT_REQ = (k == 2);
      for (n = 0; BUS_AVAILABLE !== 1'b1; n++) begin @(negedge REF_CLK); bound(n); end
      @(negedge REF_CLK);
      chk(16'(exp_q.size()), 16'h0000);
      chk({BUS_AVAILABLE, ADDR_OE_N, VALID_ADDRESS_STROBE, REQ_READY}, 4'hC);
      HALT_N = 1'b1; BUS_RELEASE_N = 1'b1; WAIT_REQ = 1'b0;
      repeat (3) @(negedge REF_CLK);
      chk(BUS_AVAILABLE, 1'b0);
    end
    $display("stop test done");
    RST = 1'b1;
    @(negedge REF_CLK);
    chk({RESET_N, RW, DATA_OE_N, BUS_AVAILABLE}, 4'h6);
    RST = 1'b0;
    @(negedge REF_CLK);
    chk({RESET_N, VALID_ADDRESS_STROBE}, 2'b10);
    chk(16'(ticks), 16'h0000);
    $display("second reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire

/* backplane_chk.sv */
/* Port checker for backplane_bus.
   Assumes default widths and one REF_CLK domain with RST high. */
`timescale 1ns/1ps
`default_nettype none
module backplane_chk
  import backplane_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        REQ_VALID,
  input wire logic        REQ_READY,
  input wire logic        RSP_VALID,
  input wire logic        RW,
  input wire logic        VALID_ADDRESS_STROBE,
  input wire logic        IO_PRESELECT,
  input wire logic [15:0] ADDR_O,
  input wire logic        ADDR_OE_N,
  input wire logic        DATA_OE_N,
  input wire logic        BUS_AVAILABLE,
  input wire logic        BUS_RELEASE_N,
  input wire logic        HALT_N,
  input wire logic        NMI_N,
  input wire logic        NMI_PENDING,
  input wire logic        IRQ_MASK,
  input wire logic [7:0]  PRIORITY_IRQ_N,
  input wire logic        IRQ_PENDING,
  input wire logic [2:0]  IRQ_LEVEL
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  rw_idle_a: assert property (!VALID_ADDRESS_STROBE |-> RW)
    else $error("write level outside a cycle");
  data_float_a: assert property (!DATA_OE_N |-> !RW && VALID_ADDRESS_STROBE)
    else $error("data driven outside a write");
  presel_map_a: assert property (IO_PRESELECT == (VALID_ADDRESS_STROBE &&
    ADDR_O >= IO_BASE && ADDR_O <= IO_LIMIT)) else $error("preselect wrong");
  cycle_len_a: assert property (REQ_VALID && REQ_READY |=> ##39 VALID_ADDRESS_STROBE
    ##1 (!VALID_ADDRESS_STROBE && RSP_VALID)) else $error("cycle length wrong");
  stop_float_a: assert property (BUS_AVAILABLE |-> ADDR_OE_N && !VALID_ADDRESS_STROBE)
    else $error("bus not released while available");
  release_float_a: assert property (!BUS_RELEASE_N [*8] |-> ##[0:60]
    (ADDR_OE_N || BUS_RELEASE_N)) else $error("address bus kept");
  halt_stop_a: assert property (!HALT_N [*8] |-> ##[0:60] (BUS_AVAILABLE || HALT_N))
    else $error("halt not honoured");
  nmi_set_a: assert property ($fell(NMI_N) |-> ##[1:2] NMI_PENDING)
    else $error("unmaskable request lost");
  irq_top_a: assert property (!IRQ_MASK && !PRIORITY_IRQ_N[7] |=>
    IRQ_PENDING && IRQ_LEVEL == 3'h7) else $error("top line not ranked first");
endmodule
bind backplane_bus backplane_chk i_chk (
  .REF_CLK(REF_CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
  .RSP_VALID(RSP_VALID), .RW(RW), .VALID_ADDRESS_STROBE(VALID_ADDRESS_STROBE),
  .IO_PRESELECT(IO_PRESELECT), .ADDR_O(ADDR_O), .ADDR_OE_N(ADDR_OE_N),
  .DATA_OE_N(DATA_OE_N), .BUS_AVAILABLE(BUS_AVAILABLE), .BUS_RELEASE_N(BUS_RELEASE_N),
  .HALT_N(HALT_N), .NMI_N(NMI_N), .NMI_PENDING(NMI_PENDING), .IRQ_MASK(IRQ_MASK),
  .PRIORITY_IRQ_N(PRIORITY_IRQ_N), .IRQ_PENDING(IRQ_PENDING), .IRQ_LEVEL(IRQ_LEVEL));
`default_nettype wire

/* backplane_pkg.sv */
/*
  Constants, types and timing figures shared by the backplane bus
  controller and its clock divider.
  Assumes a single 20 MHz reference clock.
*/
package backplane_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ        = 20_000_000;
  localparam int PHASE_CLK_HZ      = 1_000_000;
  localparam int BAUD_CLK_HZ       = 19_230;
  localparam int MAINS_HZ_LOW      = 50;
  localparam int MAINS_HZ_HIGH     = 60;
  localparam int PHASE_DIV         = REF_CLK_HZ / PHASE_CLK_HZ;
  localparam int BAUD_DIV          = REF_CLK_HZ / BAUD_CLK_HZ;
  localparam int MAINS_DIV_LOW     = REF_CLK_HZ / MAINS_HZ_LOW;
  localparam int MAINS_DIV_HIGH    = REF_CLK_HZ / MAINS_HZ_HIGH;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 8;
  localparam int          IRQ_LINES   = 8;
  localparam logic [15:0] IO_BASE     = 16'h8000;
  localparam logic [15:0] IO_LIMIT    = 16'h8FFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_RESET  = 16'h0000;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
  localparam logic [2:0]  IRQ_NONE    = 3'h0;

  typedef enum logic [1:0] {
    XFER_READ,
    XFER_WRITE
  } xfer_dir_type;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_STOPPED
  } bus_state_type;

endpackage

/* clock_gen.sv */
/*
  Divider producing the 1 MHz phase clock, the 19230 Hz baud square
  wave and the mains-rate tick from the reference clock.
  Assumes REF_CLK at 20 MHz; RST asynchronous, active high.
*/
`timescale 1ns/1ps
`default_nettype none

module clock_gen
  import backplane_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rst,
  clock_gen_if.gen    cg
);

  typedef struct packed {
    logic [4:0]  phase_cnt;
    logic [9:0]  baud_cnt;
    logic [18:0] mains_cnt;
    logic        phase_clk;
    logic        phase_fall;
    logic        baud_clk;
    logic        mains_tick;
  } div_state_type;

  div_state_type s_reg;
  div_state_type s_next;

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  always_comb begin
    s_next            = s_reg;
    s_next.phase_fall = 1'b0;
    s_next.mains_tick = 1'b0;
    // Phase clock: high half then low half, one fall flag per period
    if (s_reg.phase_cnt == 5'(PHASE_DIV - 1)) begin
      s_next.phase_cnt = '0;
    end else begin
      s_next.phase_cnt = s_reg.phase_cnt + 5'd1;
    end
    s_next.phase_clk = (s_next.phase_cnt < 5'(PHASE_DIV / 2)); // [R6]
    if (s_reg.phase_cnt == 5'(PHASE_DIV / 2 - 1)) begin
      s_next.phase_fall = 1'b1;
    end
    // Baud square wave toggles twice per period
    if (s_reg.baud_cnt == 10'(BAUD_DIV / 2 - 1)) begin
      s_next.baud_cnt = '0;
      s_next.baud_clk = ~s_reg.baud_clk; // [R14]
    end else begin
      s_next.baud_cnt = s_reg.baud_cnt + 10'd1;
    end
    // Mains tick, a single-cycle strobe at 50 or 60 Hz
    if (s_reg.mains_cnt >= (cg.mains_60hz ? 19'(MAINS_DIV_HIGH - 1)
                                          : 19'(MAINS_DIV_LOW - 1))) begin
      s_next.mains_cnt  = '0;
      s_next.mains_tick = 1'b1; // [R10]
    end else begin
      s_next.mains_cnt = s_reg.mains_cnt + 19'd1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cg.phase_clk  = s_reg.phase_clk;
  assign cg.phase_fall = s_reg.phase_fall;
  assign cg.baud_clk   = s_reg.baud_clk;
  assign cg.mains_tick = s_reg.mains_tick;

endmodule

`default_nettype wire

/* clock_gen_if.sv */
/*
  Carrier between the bus controller and its clock generator.
  Assumes both sit on REF_CLK.
*/
`timescale 1ns/1ps
`default_nettype none

interface clock_gen_if;
  logic phase_clk;
  logic phase_fall;
  logic baud_clk;
  logic mains_tick;
  logic mains_60hz;

  modport gen  (output phase_clk, output phase_fall, output baud_clk,
                output mains_tick, input mains_60hz);
  modport user (input phase_clk, input phase_fall, input baud_clk,
                input mains_tick, output mains_60hz);
endinterface

`default_nettype wire

/* io_card_model.sv */
/* Plug-in I/O card: 256 bytes in the I/O region.
   Assumes bus signals registered on clk. */
`timescale 1ns/1ps
`default_nettype none
module io_card_model (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] addr,
  input wire logic        strobe,
  input wire logic        presel,
  input wire logic        rw,
  input wire logic [7:0]  wdata,
  output logic     [7:0]  rdata
);
  logic [7:0] mem [256];
  logic [7:0] noise_reg = 8'h00;
  logic       sel;
  // Chosen by strobed address and preselect only
  assign sel = strobe && presel && addr[15:12] == 4'h8;
  always @(posedge clk) begin
    noise_reg <= rst_n ? noise_reg + 8'h3B : 8'h00;
    if (sel && !rw) mem[addr[7:0]] <= wdata;
  end
  // Released lines show changing garbage, never a stale byte
  assign rdata = (sel && rw) ? mem[addr[7:0]] : noise_reg;
endmodule
`default_nettype wire
